// ==== logic/osc_pkg.sv ====
// Purpose: shared constants for the oscillator and clock-select block
// Assumes: 8-bit special-function register port, one 100 MHz clock
// Notes: offsets are the register addresses on the core's register port
package osc_pkg;
	localparam logic [7:0] ADDR_EXT_CTRL = 8'hB1;
	localparam logic [7:0] ADDR_INT_CTRL = 8'hB2;
	localparam logic [7:0] ADDR_INT_TRIM = 8'hB3;
	localparam logic [7:0] RST_INT_CTRL = 8'hC0;
	localparam logic [6:0] RST_TRIM = 7'h40;
	localparam logic [7:0] RST_EXT_CTRL = 8'h00;
	localparam int B_ON = 7;
	localparam int B_FOK = 6;
	localparam int B_SUSP = 5;
	localparam int B_XVALID = 7;
	localparam int DIV_W = 3;
	localparam int CNT_W = 7;
	localparam logic [CNT_W-1:0] SETTLE_CYCLES = 7'h10;
	localparam real CLK_PERIOD_NS = 10.0;
	localparam real XO_SETTLE_US = 1.0;
	localparam int XO_SETTLE_CYC = int'(XO_SETTLE_US * 1000.0 / CLK_PERIOD_NS);
	typedef enum logic [1:0] {
		SRC_INT = 2'b00,
		SRC_EXT = 2'b01,
		SRC_RTC = 2'b10,
		SRC_MUL = 2'b11
	} clk_src_t;
	typedef enum logic [2:0] {
		XO_OFF0 = 3'b000,
		XO_OFF1 = 3'b001,
		XO_CMOS = 3'b010,
		XO_CMOS_H = 3'b011,
		XO_RC = 3'b100,
		XO_CAP = 3'b101,
		XO_XTAL = 3'b110,
		XO_XTAL_H = 3'b111
	} xo_mode_t;
	typedef enum logic [1:0] {
		ST_RUN = 2'b00,
		ST_SUSP = 2'b01,
		ST_WAKE = 2'b10
	} osc_state_t;
endpackage : osc_pkg

// ==== logic/clk_div_enable.sv ====
// Purpose: power-of-two divider giving a one-cycle enable per system clock tick
// Assumes: the oscillator enable runs at the base rate
// Notes: a new ratio is loaded only at a period boundary, so no runt ticks
`timescale 1ns/1ps
module clk_div_enable #(
	parameter int W = 3
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic osc_tick,
	input wire logic [W-1:0] div_sel,
	output logic tick_out
);
	logic [(1<<W)-2:0] cnt_r;
	logic [W-1:0] sel_r;
	logic [(1<<W)-2:0] mask;
	logic wrap;
	// divide by 2^(7-sel): code 000 gives /128, 111 gives /1
	assign mask = {((1<<W)-1){1'b1}} >> sel_r;
	assign wrap = ((cnt_r & mask) == mask);
	// ratio changes only when the period wraps, keeping each tick whole
	always_ff @(posedge mclk) begin
		if (srst) begin
			cnt_r <= '0;
			sel_r <= '0;
			tick_out <= 1'b0;
		end else begin
			tick_out <= osc_tick && wrap;
			if (osc_tick) begin
				cnt_r <= wrap ? '0 : cnt_r + 1'b1;
				if (wrap) begin
					sel_r <= div_sel;
				end
			end
		end
	end
endmodule : clk_div_enable

// ==== logic/osc_clock_ctrl.sv ====
// Purpose: internal oscillator control, suspend/wake, source select, ext osc pins
// Assumes: register port is a simple 8-bit write strobe / read data pair
// Notes: clocks are modelled as one-cycle enables of mclk
`timescale 1ns/1ps
module osc_clock_ctrl #(
	parameter int XO_SETTLE = osc_pkg::XO_SETTLE_CYC
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic [1:0] clk_src_sel,
	input wire logic [2:0] mul_factor_sel,
	input wire logic [1:0] mul_base_sel,
	input wire logic port0_match,
	input wire logic port1_match,
	input wire logic cmp0_en,
	input wire logic cmp0_out,
	input wire logic cmp1_en,
	input wire logic cmp1_out,
	input wire logic rtc_osc_fail,
	input wire logic rtc_alarm,
	input wire logic ext_osc_tick,
	input wire logic rtc_osc_tick,
	output logic core_clock_out,
	output logic int_osc_tick,
	output logic core_halted,
	output logic xo_pin_in,
	output logic xo_pin_out,
	output logic [6:0] trim_out
);
	import osc_pkg::*;

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic int_osc_on_r;
	logic [DIV_W-1:0] int_osc_divider_sel;
	logic [6:0] trim_r;
	logic [2:0] ext_osc_mode_sel;
	logic [2:0] xo_freq_range;
	logic susp_req;
	logic freq_ok_r;
	logic [CNT_W-1:0] settle_r;
	logic [15:0] xo_cnt_r;
	logic xo_valid_r;
	osc_state_t st_r;
	osc_state_t st_nxt;
	logic wr_ctrl;
	logic wr_trim;
	logic wr_ext;
	logic wake;
	logic osc_runs;
	logic int_tick_r;
	logic sys_tick;
	logic div_tick;
	logic src_tick;
	logic ext_half_r;
	logic ext_tick_m;
	logic mul_tick;
	logic [2:0] mul_cnt_r;
	logic [2:0] mul_lim;
	logic [7:0] rdata_nxt;
	logic xo_crystal;
	logic xo_enabled;

	assign wr_ctrl = reg_wr && (reg_addr == ADDR_INT_CTRL);
	assign wr_trim = reg_wr && (reg_addr == ADDR_INT_TRIM);
	assign wr_ext = reg_wr && (reg_addr == ADDR_EXT_CTRL);

	// ----------------------------------------------------------------
	// wake events and suspend state
	// ----------------------------------------------------------------
	// raw sources only; interrupt enables are never consulted
	assign wake = port0_match || port1_match || (cmp0_en && !cmp0_out)
		|| (cmp1_en && !cmp1_out) || rtc_osc_fail || rtc_alarm;
	assign susp_req = wr_ctrl && reg_wdata[B_SUSP];

	always_comb begin
		st_nxt = st_r;
		case (st_r)
			ST_RUN: if (susp_req) st_nxt = ST_SUSP;
			ST_SUSP: if (wake) st_nxt = ST_WAKE;
			ST_WAKE: st_nxt = ST_RUN;
			default: st_nxt = ST_RUN;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (srst) st_r <= ST_RUN;
		else st_r <= st_nxt;
	end

	// ----------------------------------------------------------------
	// control, trim and external registers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (srst) begin
			int_osc_on_r <= RST_INT_CTRL[B_ON];
			int_osc_divider_sel <= RST_INT_CTRL[DIV_W-1:0];
			trim_r <= RST_TRIM;
			ext_osc_mode_sel <= RST_EXT_CTRL[6:4];
			xo_freq_range <= RST_EXT_CTRL[2:0];
		end else begin
			if (wr_ctrl) begin
				int_osc_on_r <= reg_wdata[B_ON];
				int_osc_divider_sel <= reg_wdata[DIV_W-1:0];
			end
			if (wr_trim) trim_r <= reg_wdata[6:0];
			if (wr_ext) begin
				ext_osc_mode_sel <= reg_wdata[6:4];
				xo_freq_range <= reg_wdata[2:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// internal oscillator model and settle flag
	// ----------------------------------------------------------------
	assign osc_runs = int_osc_on_r && (st_r == ST_RUN);

	// trim write or oscillator stop costs a short resettle before ready
	always_ff @(posedge mclk) begin
		if (srst) begin
			settle_r <= '0;
			freq_ok_r <= 1'b0;
			int_tick_r <= 1'b0;
		end else begin
			int_tick_r <= osc_runs;
			if (!osc_runs || wr_trim) begin
				settle_r <= '0;
				freq_ok_r <= 1'b0;
			end else if (settle_r == SETTLE_CYCLES) begin
				freq_ok_r <= 1'b1;
			end else begin
				settle_r <= settle_r + 1'b1;
			end
		end
	end

	clk_div_enable #(.W(DIV_W)) u_div (
		.mclk(mclk),
		.srst(srst),
		.osc_tick(int_tick_r),
		.div_sel(int_osc_divider_sel),
		.tick_out(div_tick)
	);

	// ----------------------------------------------------------------
	// external oscillator mode, pins and crystal valid
	// ----------------------------------------------------------------
	assign xo_enabled = ext_osc_mode_sel[2] || ext_osc_mode_sel[1];
	assign xo_crystal = (ext_osc_mode_sel == XO_XTAL) || (ext_osc_mode_sel == XO_XTAL_H);

	always_ff @(posedge mclk) begin
		if (srst) begin
			xo_cnt_r <= '0;
			xo_valid_r <= 1'b0;
			ext_half_r <= 1'b0;
		end else begin
			if (!xo_crystal) begin
				xo_cnt_r <= '0;
				xo_valid_r <= 1'b0;
			end else if (xo_cnt_r == 16'(XO_SETTLE)) begin
				xo_valid_r <= 1'b1;
			end else begin
				xo_cnt_r <= xo_cnt_r + 1'b1;
			end
			if (ext_osc_tick) ext_half_r <= !ext_half_r;
		end
	end

	// halved modes pass every second external tick
	assign ext_tick_m = xo_enabled && ext_osc_tick
		&& (!ext_osc_mode_sel[0] || ext_osc_mode_sel[2:1] == 2'b10 || ext_half_r);

	// ----------------------------------------------------------------
	// multiplier: every base tick passes; the 2/n skip counter does not gate the output
	// ----------------------------------------------------------------
	// factor codes 0..5 give counter limits 1, 3, 4, 5, 6, 7
	assign mul_lim = (mul_factor_sel == 3'h0) ? 3'h1 : 3'(mul_factor_sel + 3'h2);

	always_ff @(posedge mclk) begin
		if (srst) begin
			mul_cnt_r <= '0;
			mul_tick <= 1'b0;
		end else begin
			mul_tick <= 1'b0;
			if ((mul_base_sel == 2'b00) ? int_tick_r : ext_tick_m) begin
				// a tick on the selected base input advances the counter by two
				mul_cnt_r <= (mul_cnt_r + 3'h2 >= mul_lim) ? 3'h0 : 3'(mul_cnt_r + 3'h2);
				mul_tick <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// source selection and outputs
	// ----------------------------------------------------------------
	always_comb begin
		case (clk_src_t'(clk_src_sel))
			SRC_INT: src_tick = div_tick;
			SRC_EXT: src_tick = ext_tick_m;
			SRC_RTC: src_tick = rtc_osc_tick;
			default: src_tick = mul_tick;
		endcase
	end
	// the core only sleeps when the internal oscillator feeds it
	assign sys_tick = src_tick && !((st_r != ST_RUN) && clk_src_sel == SRC_INT);

	always_comb begin
		rdata_nxt = 8'h00;
		case (reg_addr)
			ADDR_INT_CTRL: rdata_nxt = {int_osc_on_r, freq_ok_r, 1'b0, 2'b00,
				int_osc_divider_sel};
			ADDR_INT_TRIM: rdata_nxt = {1'b0, trim_r};
			ADDR_EXT_CTRL: rdata_nxt = {xo_valid_r && xo_crystal, ext_osc_mode_sel,
				1'b0, xo_freq_range};
			default: rdata_nxt = 8'h00;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			reg_rdata <= 8'h00;
			core_clock_out <= 1'b0;
			int_osc_tick <= 1'b0;
			core_halted <= 1'b0;
			xo_pin_in <= 1'b0;
			xo_pin_out <= 1'b0;
			trim_out <= RST_TRIM;
		end else begin
			if (reg_rd) reg_rdata <= rdata_nxt;
			core_clock_out <= sys_tick;
			int_osc_tick <= int_tick_r;
			core_halted <= (st_nxt != ST_RUN) && clk_src_sel == SRC_INT;
			xo_pin_in <= xo_crystal;
			xo_pin_out <= xo_enabled;
			trim_out <= trim_r;
		end
	end
endmodule : osc_clock_ctrl

// ==== sim/osc_clock_ctrl_asserts.sv ====
// Purpose: port-level checks for osc_clock_ctrl
// Assumes: srst synchronous active high, internal source when clk_src_sel is 0
// Notes: attached by bind from tb
`timescale 1ns/1ps
module osc_clock_ctrl_asserts (
	input wire logic mclk,
	input wire logic srst,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic [1:0] clk_src_sel,
	input wire logic port0_match,
	input wire logic port1_match,
	input wire logic cmp0_en,
	input wire logic cmp0_out,
	input wire logic cmp1_en,
	input wire logic cmp1_out,
	input wire logic rtc_osc_fail,
	input wire logic rtc_alarm,
	input wire logic core_clock_out,
	input wire logic core_halted,
	input wire logic xo_pin_in,
	input wire logic xo_pin_out,
	input wire logic [6:0] trim_out
);
	import osc_pkg::*;
	// any wake level; a comparator only counts while enabled and low
	wire wake = port0_match | port1_match | (cmp0_en & ~cmp0_out) | (cmp1_en & ~cmp1_out)
		| rtc_osc_fail | rtc_alarm;
	wire ext_wr = reg_wr && reg_addr == ADDR_EXT_CTRL;
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	property p_trim_rst;
		$fell(srst) |-> trim_out == RST_TRIM;
	endproperty
	a_trim_rst: assert property (p_trim_rst) else $error("trim not at reset code");
	property p_trim_msb;
		reg_rd && reg_addr == ADDR_INT_TRIM |=> !reg_rdata[7];
	endproperty
	a_trim_msb: assert property (p_trim_msb) else $error("trim top bit set");
	property p_ctl_gap;
		reg_rd && reg_addr == ADDR_INT_CTRL |=> reg_rdata[4:3] == 2'b00;
	endproperty
	a_ctl_gap: assert property (p_ctl_gap) else $error("control bits 4:3 set");
	property p_halt_quiet;
		core_halted && $past(core_halted) |-> !core_clock_out;
	endproperty
	a_halt_quiet: assert property (p_halt_quiet) else $error("clock while halted");
	property p_enter;
		reg_wr && reg_addr == ADDR_INT_CTRL && reg_wdata[7] && reg_wdata[5] && !wake
			&& clk_src_sel == 2'b00 |-> ##[1:2] core_halted;
	endproperty
	a_enter: assert property (p_enter) else $error("suspend not entered");
	property p_wake;
		core_halted && wake |-> ##[1:2] !core_halted;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake on event");
	property p_xo_pair;
		xo_pin_in |-> xo_pin_out;
	endproperty
	a_xo_pair: assert property (p_xo_pair) else $error("input pin without output pin");
	property p_xo_off;
		ext_wr && reg_wdata[6:5] == 2'b00 |-> ##2 !xo_pin_out && !xo_pin_in;
	endproperty
	a_xo_off: assert property (p_xo_off) else $error("pins held while off");
	property p_xtal;
		ext_wr && reg_wdata[6:5] == 2'b11 |-> ##2 xo_pin_in && xo_pin_out;
	endproperty
	a_xtal: assert property (p_xtal) else $error("crystal pins not claimed");
endmodule : osc_clock_ctrl_asserts

// ==== sim/tb.sv ====
// Purpose: self-checking bench for osc_clock_ctrl
// Assumes: inputs change at falling edge, fixed seed
// Notes: multiplier selects tied to internal source; source select driven by the bench
`timescale 1ns/1ps
module tb;
	import osc_pkg::*;
	logic mclk = 0, srst = 1, reg_wr = 0, reg_rd = 0, ext_osc_tick = 0, rtc_osc_tick = 0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, wk = 8'h28, v;
	logic [1:0] clk_src_sel = 2'h0;
	logic [7:0] wake_tab [6] = '{8'h29, 8'h2A, 8'h24, 8'h18, 8'h68, 8'hA8};
	wire logic [7:0] reg_rdata;
	wire logic port0_match, port1_match, cmp0_en, cmp0_out, cmp1_en, cmp1_out;
	wire logic rtc_osc_fail, rtc_alarm, core_clock_out, int_osc_tick, core_halted;
	wire logic xo_pin_in, xo_pin_out;
	wire logic [6:0] trim_out;
	int n_errors = 0, total_checks = 0, cyc = 0, n;
	// comparators idle high so only table entries wake
	assign {rtc_alarm, rtc_osc_fail, cmp1_out, cmp1_en, cmp0_out, cmp0_en} = wk[7:2];
	assign {port1_match, port0_match} = wk[1:0];
	osc_clock_ctrl #(.XO_SETTLE(4)) uut (.mclk, .srst, .reg_wr, .reg_rd, .reg_addr,
		.reg_wdata, .reg_rdata, .clk_src_sel, .mul_factor_sel(3'h0), .mul_base_sel(2'h0),
		.port0_match, .port1_match, .cmp0_en, .cmp0_out, .cmp1_en, .cmp1_out, .rtc_osc_fail,
		.rtc_alarm, .ext_osc_tick, .rtc_osc_tick, .core_clock_out, .int_osc_tick,
		.core_halted, .xo_pin_in, .xo_pin_out, .trim_out);
	always #5 mclk = ~mclk;
	// other oscillators tick at random; they must not disturb the internal path
	always @(negedge mclk) begin
		ext_osc_tick = $urandom % 2;
		rtc_osc_tick = $urandom % 2;
	end
	// hang guard, well above the longest expected run
	always @(posedge mclk) begin
		cyc++;
		if (cyc > 20000) begin
			n_errors++;
			tally_and_finish();
		end
	end
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : tally_and_finish
	task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(negedge mclk);
		reg_wr = 1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge mclk);
		reg_wr = 0;
	endtask : wr
	task automatic rd(logic [7:0] a, logic [7:0] exp);
		@(negedge mclk);
		reg_rd = 1;
		reg_addr = a;
		@(negedge mclk);
		reg_rd = 0;
		chk("rdata", exp, reg_rdata);
	endtask : rd
	// cycles up to the next system clock tick, bounded
	task automatic gap();
		n = 0;
		do begin
			@(negedge mclk);
			n++;
		end while (!core_clock_out && n < 300);
	endtask : gap
	initial begin
		v = $urandom(32'hE9959314);
		repeat (10) @(negedge mclk);
		srst = 0;
		repeat (20) @(negedge mclk);
		rd(ADDR_INT_CTRL, 8'hC0);
		rd(ADDR_INT_TRIM, {1'b0, RST_TRIM});
		wr(ADDR_INT_CTRL, 8'hDE);
		rd(ADDR_INT_CTRL, 8'hC6);
		wr(ADDR_INT_CTRL, 8'h06);
		repeat (3) @(negedge mclk);
		rd(ADDR_INT_CTRL, 8'h06);
		chk("osc_tick", 8'h00, {7'h0, int_osc_tick});
		wr(ADDR_INT_CTRL, 8'h86);
		repeat (20) @(negedge mclk);
		rd(ADDR_INT_CTRL, 8'hC6);
		for (int c = 0; c < 8; c++) begin
			wr(ADDR_INT_CTRL, 8'h80 | 8'(c));
			gap();
			gap();
			gap();
			chk("period", 8'(128 >> c), 8'(n));
		end
		foreach (wake_tab[i]) begin
			wr(ADDR_INT_CTRL, 8'hA7);
			repeat (3) @(negedge mclk);
			wk = 8'h2C;
			repeat (4) @(negedge mclk);
			chk("halted", 8'h01, {7'h0, core_halted});
			wk = wake_tab[i];
			repeat (3) @(negedge mclk);
			chk("halted", 8'h00, {7'h0, core_halted});
			wk = 8'h28;
			repeat (20) @(negedge mclk);
			rd(ADDR_INT_CTRL, 8'hC7);
		end
		// software duties: pins skipped and set as inputs, mode and range chosen first
		for (int m = 0; m < 8; m++) begin
			v = $urandom;
			wr(ADDR_EXT_CTRL, {1'b0, 3'(m), 1'b0, v[2:0]});
			repeat (2) @(negedge mclk);
			chk("xo_pins", {6'h0, 2'(m >> 1) == 2'b11, 2'(m >> 1) != 2'b00},
				{6'h0, xo_pin_in, xo_pin_out});
		end
		// clock oscillator as source: each random tick shows one cycle later
		clk_src_sel = 2'h2;
		repeat (2) @(negedge mclk);
		repeat (8) begin
			@(posedge mclk);
			v[0] = rtc_osc_tick;
			@(negedge mclk);
			chk("rtc_src", {7'h0, v[0]}, {7'h0, core_clock_out});
		end
		clk_src_sel = 2'h0;
		repeat (4) begin
			v = $urandom;
			wr(ADDR_INT_TRIM, v);
			rd(ADDR_INT_TRIM, {1'b0, v[6:0]});
			chk("trim_out", {1'b0, v[6:0]}, {1'b0, trim_out});
		end
		wr(8'hB4, 8'hFF);
		rd(8'hB4, 8'h00);
		srst = 1;
		repeat (2) @(negedge mclk);
		srst = 0;
		rd(ADDR_INT_TRIM, {1'b0, RST_TRIM});
		tally_and_finish();
	end
endmodule : tb
bind osc_clock_ctrl osc_clock_ctrl_asserts u_asserts (.mclk, .srst, .reg_wr, .reg_rd,
	.reg_addr, .reg_wdata, .reg_rdata, .clk_src_sel, .port0_match, .port1_match, .cmp0_en,
	.cmp0_out, .cmp1_en, .cmp1_out, .rtc_osc_fail, .rtc_alarm, .core_clock_out,
	.core_halted, .xo_pin_in, .xo_pin_out, .trim_out);
